/* rtl/cdrf_top.sv */
// Clock recovery front end: serial registers, recovery loops, retiming FIFO
`timescale 1ns/1ps
`default_nettype none
module cdrf_top
	import cdrf_pkg::*;
#(
	parameter int         WIN_CYC  = 4096,
	parameter int         OSC_W    = 12,
	parameter int         PHASE_W  = 8,
	parameter int         DIV_MAX  = 10,
	parameter int         FIFO_DEP = 32,
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Serial register port
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	// Sampled line and oscillator
	input  wire logic               din_smp,
	input  wire logic               edge_smp,
	input  wire logic               osc_tick,
	input  wire logic               data_tick,
	input  wire logic               retime_tick,
	input  wire logic [3:0]         adapt_gain,
	// Front end controls
	output logic                    term_float,
	output logic [1:0]              eq_path,
	output logic                    auto_equalize_enable,
	output logic [3:0]              equalizer_gain,
	// Output stage controls
	output logic                    dout,
	output logic                    output_off_bit,
	output logic                    ddr_clk_off,
	output logic [3:0]              swing,
	// Loop state
	output logic [OSC_W-1:0]        digital_oscillator,
	output logic [PHASE_W-1:0]      phase_word,
	output logic [3:0]              div_exp,
	output logic                    lock_loss_flag
);

	localparam int               AW        = $clog2(FIFO_DEP);
	localparam int               CW        = 24;
	localparam logic [OSC_W-1:0] OSC_MAX   = '1;
	localparam logic [OSC_W-1:0] STEP_INIT = OSC_W'(1) << (OSC_W - 3);

	if (FIFO_DEP < FIFO_UI || (FIFO_DEP & (FIFO_DEP - 1)) != 0 || DIV_MAX > 15
		|| OSC_W < 4 || WIN_CYC < 16 || WIN_CYC > 1000000) begin : g_bad
		$error("cdrf_top: unsupported parameters");
	end

	// =============================================================
	// Input synchronisers
	logic [5:0]   sy1_ff;
	logic [5:0]   sy2_ff;
	logic [5:0]   sy3_ff;
	logic         scl_rise;
	logic         scl_fall;
	logic         i2c_start;
	logic         i2c_stop;
	logic         osc_pulse;
	logic         data_pulse;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sy1_ff <= RST_SYNC;
			sy2_ff <= RST_SYNC;
			sy3_ff <= RST_SYNC;
		end else begin
			sy1_ff <= {data_tick, osc_tick, edge_smp, din_smp, sda_in, scl_in};
			sy2_ff <= sy1_ff;
			sy3_ff <= sy2_ff;
		end
	end

	assign scl_rise   = sy2_ff[0] & ~sy3_ff[0];
	assign scl_fall   = ~sy2_ff[0] & sy3_ff[0];
	assign i2c_start  = sy2_ff[0] & sy3_ff[0] & ~sy2_ff[1] & sy3_ff[1];
	assign i2c_stop   = sy2_ff[0] & sy3_ff[0] & sy2_ff[1] & ~sy3_ff[1];
	assign osc_pulse  = sy2_ff[4] & ~sy3_ff[4];
	assign data_pulse = sy2_ff[5] & ~sy3_ff[5];

	// =============================================================
	// Serial register slave
	cdrf_i2c_type i2c_st_ff;
	logic [3:0]   bit_ff;
	logic [7:0]   sh_ff;
	logic [7:0]   tx_ff;
	logic [7:0]   ptr_ff;
	logic         rw_ff;
	logic         nack_ff;
	logic         sda_oe_ff;
	logic         sda_out_ff;
	logic         wr_pulse_ff;
	logic [7:0]   wr_addr_ff;
	logic [7:0]   wr_data_ff;
	logic [7:0]   rd_cur;
	logic [7:0]   in_stage_ff;
	logic [7:0]   out_ctrl_ff;
	logic [7:0]   out_swing_ff;
	logic [3:0]   div_ff;
	logic         loss_ff;
	logic         ovf_ff;

	always_comb begin
		case (ptr_ff)
			OFS_INPUT_STAGE: rd_cur = in_stage_ff;
			OFS_OUT_CTRL:    rd_cur = out_ctrl_ff;
			OFS_OUT_SWING:   rd_cur = out_swing_ff;
			OFS_STATUS:      rd_cur = {loss_ff, ovf_ff, 2'h0, div_ff};
			default:         rd_cur = 8'h00;
		endcase
	end

	// Open drain: only ever pulls low, release lets the bus float high
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			i2c_st_ff   <= I_IDLE;
			bit_ff      <= 4'h0;
			sh_ff       <= 8'h00;
			tx_ff       <= 8'h00;
			ptr_ff      <= 8'h00;
			rw_ff       <= 1'b0;
			nack_ff     <= 1'b0;
			sda_oe_ff   <= 1'b0;
			sda_out_ff  <= 1'b0;
			wr_pulse_ff <= 1'b0;
			wr_addr_ff  <= 8'h00;
			wr_data_ff  <= 8'h00;
		end else begin
			wr_pulse_ff <= 1'b0;
			if (i2c_start) begin
				i2c_st_ff <= I_ADDR;
				// The fall that ends START is no data bit: it wraps the count to 0
				bit_ff    <= 4'hF;
				sda_oe_ff <= 1'b0;
			end else if (i2c_stop) begin
				i2c_st_ff <= I_IDLE;
				sda_oe_ff <= 1'b0;
			end else if (i2c_st_ff != I_IDLE) begin
				if (scl_rise) begin
					if (bit_ff == 4'h8) nack_ff <= sy2_ff[1];
					else sh_ff <= {sh_ff[6:0], sy2_ff[1]};
				end else if (scl_fall && bit_ff == 4'h7) begin
					bit_ff    <= 4'h8;
					sda_oe_ff <= 1'b1;
					unique case (i2c_st_ff)
						I_ADDR: begin
							rw_ff <= sh_ff[0];
							if (sh_ff[7:1] != DEV_ADDR) begin
								sda_oe_ff <= 1'b0;
								i2c_st_ff <= I_IDLE;
							end
						end
						I_PTR: ptr_ff <= sh_ff;
						I_WR: begin
							wr_pulse_ff <= 1'b1;
							wr_addr_ff  <= ptr_ff;
							wr_data_ff  <= sh_ff;
							ptr_ff      <= ptr_ff + 8'h01;
						end
						I_RD: begin
							sda_oe_ff <= 1'b0;
							ptr_ff    <= ptr_ff + 8'h01;
						end
						default: sda_oe_ff <= 1'b0;
					endcase
				end else if (scl_fall && bit_ff == 4'h8) begin
					bit_ff    <= 4'h0;
					sda_oe_ff <= 1'b0;
					unique case (i2c_st_ff)
						I_ADDR: begin
							if (rw_ff) begin
								i2c_st_ff <= I_RD;
								tx_ff     <= rd_cur;
								sda_oe_ff <= ~rd_cur[7];
							end else begin
								i2c_st_ff <= I_PTR;
							end
						end
						I_PTR: i2c_st_ff <= I_WR;
						I_RD: begin
							if (nack_ff) begin
								i2c_st_ff <= I_IDLE;
							end else begin
								tx_ff     <= rd_cur;
								sda_oe_ff <= ~rd_cur[7];
							end
						end
						default: ;
					endcase
				end else if (scl_fall) begin
					bit_ff <= bit_ff + 4'h1;
					if (i2c_st_ff == I_RD) begin
						tx_ff     <= {tx_ff[6:0], 1'b0};
						sda_oe_ff <= ~tx_ff[6];
					end
				end
			end
		end
	end

	// =============================================================
	// Configuration registers
	// Unmapped offsets swallow the write and read back zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_stage_ff  <= RST_INPUT_STAGE;
			out_ctrl_ff  <= RST_OUT_CTRL;
			out_swing_ff <= RST_OUT_SWING;
		end else if (wr_pulse_ff) begin
			case (wr_addr_ff)
				OFS_INPUT_STAGE: in_stage_ff  <= wr_data_ff;
				OFS_OUT_CTRL:    out_ctrl_ff  <= wr_data_ff;
				OFS_OUT_SWING:   out_swing_ff <= wr_data_ff;
				default: ;
			endcase
		end
	end

	// Gain follows the adaptation loop only while automatic mode is set
	logic [3:0] gain_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) gain_ff <= RST_INPUT_STAGE[GAIN_HI:0];
		else if (in_stage_ff[BIT_AUTO_EQ]) gain_ff <= adapt_gain;
		else gain_ff <= in_stage_ff[GAIN_HI:0];
	end

	// =============================================================
	// Downsampler and bang-bang phase detector
	logic [15:0] ds_cnt_ff;
	logic [15:0] ds_load;
	logic        ds_stb_ff;
	logic        d_cur_ff;
	logic        d_prev_ff;
	logic        e_ff;
	logic        pd_up_ff;
	logic        pd_dn_ff;

	assign ds_load = 16'((32'd1 << div_ff) - 32'd1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ds_cnt_ff <= 16'h0000;
			ds_stb_ff <= 1'b0;
			d_cur_ff  <= 1'b0;
			d_prev_ff <= 1'b0;
			e_ff      <= 1'b0;
		end else if (ds_cnt_ff == 16'h0000) begin
			ds_cnt_ff <= ds_load;
			ds_stb_ff <= 1'b1;
			d_cur_ff  <= sy2_ff[2];
			d_prev_ff <= d_cur_ff;
			e_ff      <= sy2_ff[3];
		end else begin
			ds_cnt_ff <= ds_cnt_ff - 16'h0001;
			ds_stb_ff <= 1'b0;
		end
	end

	// Edge sample equal to new bit means the clock is late
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pd_up_ff <= 1'b0;
			pd_dn_ff <= 1'b0;
		end else begin
			pd_up_ff <= ds_stb_ff & (d_cur_ff != d_prev_ff) & (e_ff == d_cur_ff);
			pd_dn_ff <= ds_stb_ff & (d_cur_ff != d_prev_ff) & (e_ff == d_prev_ff);
		end
	end

	// =============================================================
	// Frequency measurement window
	logic [CW-1:0] win_ff;
	logic [CW-1:0] samp_cnt_ff;
	logic [CW-1:0] data_cnt_ff;
	logic [CW-1:0] meas_a_ff;
	logic [CW-1:0] meas_b_ff;
	logic [15:0]   presc_ff;
	logic          eval_ff;
	logic [CW-1:0] diff;
	logic          samp_fast;
	logic          over_loss;
	logic          in_lock;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			win_ff      <= '0;
			samp_cnt_ff <= '0;
			data_cnt_ff <= '0;
			meas_a_ff   <= '0;
			meas_b_ff   <= '0;
			presc_ff    <= 16'h0000;
			eval_ff     <= 1'b0;
		end else begin
			eval_ff <= 1'b0;
			if (osc_pulse) presc_ff <= (presc_ff >= ds_load) ? 16'h0000 : presc_ff + 16'h0001;
			if (win_ff == CW'(WIN_CYC - 1)) begin
				win_ff      <= '0;
				meas_a_ff   <= samp_cnt_ff;
				meas_b_ff   <= data_cnt_ff;
				samp_cnt_ff <= '0;
				data_cnt_ff <= '0;
				eval_ff     <= 1'b1;
			end else begin
				win_ff <= win_ff + CW'(1);
				if (osc_pulse && presc_ff >= ds_load) samp_cnt_ff <= samp_cnt_ff + CW'(1);
				if (data_pulse) data_cnt_ff <= data_cnt_ff + CW'(1);
			end
		end
	end

	assign samp_fast = meas_a_ff > meas_b_ff;
	assign diff      = samp_fast ? meas_a_ff - meas_b_ff : meas_b_ff - meas_a_ff;
	assign over_loss = 48'(diff) * 48'(PPM_SCALE) > 48'(LOSS_PPM) * 48'(meas_b_ff);
	assign in_lock   = 48'(diff) * 48'(PPM_SCALE) <= 48'(LOCK_PPM) * 48'(meas_b_ff);

	// =============================================================
	// Acquisition machine and oscillator integrator
	cdrf_acq_type        acq_st_ff;
	logic [OSC_W-1:0]    osc_ff;
	logic [OSC_W-1:0]    step_ff;
	logic [OSC_W:0]      osc_sum;
	logic [OSC_W-1:0]    step_half;

	assign osc_sum   = {1'b0, osc_ff} + {1'b0, step_ff};
	assign step_half = (step_ff > OSC_W'(1)) ? step_ff >> 1 : step_ff;

	// Frequency loop only checks for lock loss while tracking; otherwise only the phase detector moves the word
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acq_st_ff <= A_ACQ;
			osc_ff    <= '0;
			div_ff    <= 4'h0;
			step_ff   <= STEP_INIT;
			loss_ff   <= 1'b1;
		end else if (eval_ff && acq_st_ff == A_TRACK && over_loss) begin
			loss_ff   <= 1'b1;
			osc_ff    <= '0;
			div_ff    <= 4'h0;
			step_ff   <= STEP_INIT;
			acq_st_ff <= A_ACQ;
		end else if (eval_ff && acq_st_ff == A_ACQ) begin
			if (in_lock) begin
				loss_ff   <= 1'b0;
				acq_st_ff <= A_TRACK;
			end else if (samp_fast) begin
				if (step_ff == STEP_INIT && div_ff < 4'(DIV_MAX)) begin
					div_ff <= div_ff + 4'h1;
				end else begin
					osc_ff  <= (osc_ff > step_ff) ? osc_ff - step_ff : '0;
					step_ff <= step_half;
				end
			end else begin
				osc_ff <= osc_sum[OSC_W] ? OSC_MAX : osc_sum[OSC_W-1:0];
				if (diff < (meas_b_ff >> 3)) step_ff <= step_half;
			end
		end else if (acq_st_ff == A_TRACK) begin
			// Pure integrator: no proportional path, so static error ends at zero
			if (pd_up_ff && osc_ff != OSC_MAX) osc_ff <= osc_ff + OSC_W'(1);
			else if (pd_dn_ff && osc_ff != '0) osc_ff <= osc_ff - OSC_W'(1);
		end
	end

	// Delay loop: wraps freely, so it keeps tracking after the oscillator saturates
	logic [PHASE_W-1:0] phase_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) phase_ff <= '0;
		else if (acq_st_ff == A_TRACK && pd_up_ff) phase_ff <= phase_ff - PHASE_W'(1);
		else if (acq_st_ff == A_TRACK && pd_dn_ff) phase_ff <= phase_ff + PHASE_W'(1);
	end

	// =============================================================
	// Retiming FIFO and output stage
	logic          mem_ff [FIFO_DEP];
	logic [AW:0]   wptr_ff;
	logic [AW:0]   rptr_ff;
	logic [AW:0]   level;
	logic          wr_en;
	logic          rd_en;
	logic          fifo_q;
	logic          dout_ff;

	assign level  = wptr_ff - rptr_ff;
	assign wr_en  = ds_stb_ff && level != (AW+1)'(FIFO_DEP);
	assign rd_en  = retime_tick && level != '0;
	assign fifo_q = mem_ff[rptr_ff[AW-1:0]];

	always_ff @(posedge clk) begin
		if (wr_en) mem_ff[wptr_ff[AW-1:0]] <= d_cur_ff;
	end

	// Overflow set wins over the clear from a new acquisition
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			ovf_ff  <= 1'b0;
			dout_ff <= 1'b0;
		end else begin
			if (wr_en) wptr_ff <= wptr_ff + (AW+1)'(1);
			if (ds_stb_ff && !wr_en) ovf_ff <= 1'b1;
			else if (eval_ff && over_loss && acq_st_ff == A_TRACK) ovf_ff <= 1'b0;
			if (rd_en) begin
				rptr_ff <= rptr_ff + (AW+1)'(1);
				if (out_ctrl_ff[BIT_SQUELCH]) dout_ff <= 1'b0;
				else dout_ff <= fifo_q ^ out_ctrl_ff[BIT_POLARITY];
			end
		end
	end

	assign sda_out              = sda_out_ff;
	assign sda_oe               = sda_oe_ff;
	assign term_float           = in_stage_ff[BIT_TERM_FLOAT];
	assign eq_path              = in_stage_ff[SEL_HI:SEL_LO];
	assign auto_equalize_enable = in_stage_ff[BIT_AUTO_EQ];
	assign equalizer_gain       = gain_ff;
	assign dout                 = dout_ff;
	assign output_off_bit       = out_ctrl_ff[BIT_OUTPUT_OFF];
	assign ddr_clk_off          = out_ctrl_ff[BIT_DDR_OFF];
	assign swing                = out_swing_ff[SWING_HI:SWING_LO];
	assign digital_oscillator   = osc_ff;
	assign phase_word           = phase_ff;
	assign div_exp              = div_ff;
	assign lock_loss_flag       = loss_ff;

	// =============================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_term_write: assert property (wr_pulse_ff && wr_addr_ff == OFS_INPUT_STAGE
		|=> term_float == $past(wr_data_ff[BIT_TERM_FLOAT]))
		else $error("termination bit not taken from write");
	a_path_write: assert property (wr_pulse_ff && wr_addr_ff == OFS_INPUT_STAGE
		|=> eq_path == $past(wr_data_ff[SEL_HI:SEL_LO]))
		else $error("front-end select not taken from write");
	a_gain_manual: assert property (!in_stage_ff[BIT_AUTO_EQ] [*2]
		|-> equalizer_gain == $past(in_stage_ff[GAIN_HI:0]))
		else $error("manual gain not applied");
	a_gain_auto: assert property (in_stage_ff[BIT_AUTO_EQ]
		|=> equalizer_gain == $past(adapt_gain))
		else $error("adaptive gain not applied");
	a_ctrl_write: assert property (wr_pulse_ff && wr_addr_ff == OFS_OUT_CTRL
		|=> ddr_clk_off == $past(wr_data_ff[BIT_DDR_OFF])
		&& output_off_bit == $past(wr_data_ff[BIT_OUTPUT_OFF]))
		else $error("output control bits not taken");
	a_swing_write: assert property (wr_pulse_ff && wr_addr_ff == OFS_OUT_SWING
		|=> swing == $past(wr_data_ff[SWING_HI:SWING_LO]))
		else $error("swing field not taken");
	a_squelch_zero: assert property (rd_en && out_ctrl_ff[BIT_SQUELCH] |=> !dout)
		else $error("squelched data not zero");
	a_data_polarity: assert property (rd_en && !out_ctrl_ff[BIT_SQUELCH]
		|=> dout == ($past(fifo_q) ^ $past(out_ctrl_ff[BIT_POLARITY])))
		else $error("output polarity wrong");
	a_loss_restart: assert property (eval_ff && acq_st_ff == A_TRACK && over_loss
		|=> lock_loss_flag && osc_ff == '0 && div_ff == 4'h0 && acq_st_ff == A_ACQ)
		else $error("lock loss did not restart acquisition");
	a_lock_clear: assert property (eval_ff && acq_st_ff == A_ACQ && in_lock
		|=> !lock_loss_flag ##1 acq_st_ff == A_TRACK)
		else $error("lock loss not cleared inside 250 ppm");
	a_lag_action: assert property (acq_st_ff == A_TRACK && pd_up_ff && !eval_ff
		&& osc_ff != OSC_MAX |=> osc_ff == $past(osc_ff) + OSC_W'(1)
		&& phase_ff == $past(phase_ff) - PHASE_W'(1))
		else $error("late clock not corrected by both loops");
	a_osc_saturate: assert property (acq_st_ff == A_TRACK && pd_up_ff && !eval_ff
		&& osc_ff == OSC_MAX |=> osc_ff == OSC_MAX && phase_ff != $past(phase_ff))
		else $error("saturated oscillator moved or phase stalled");
	a_fifo_bound: assert property (level <= (AW+1)'(FIFO_DEP))
		else $error("retiming FIFO level above depth");
	a_fifo_write: assert property (ds_stb_ff && level < (AW+1)'(FIFO_UI) |=> level != '0)
		else $error("retiming FIFO lost a written bit");

	c_lock_reached: cover property (acq_st_ff == A_ACQ ##1 acq_st_ff == A_TRACK);
	c_loss_restart: cover property (acq_st_ff == A_TRACK ##1 acq_st_ff == A_ACQ);
	c_ratio_double: cover property (eval_ff && acq_st_ff == A_ACQ ##1 div_ff == 4'h1);
	c_fifo_full:    cover property (level == (AW+1)'(FIFO_DEP));

endmodule : cdrf_top
`default_nettype wire

/* shared/cdrf_pkg.sv */
// Constants and types of the clock recovery front end and output control
// =============================================================
// How it works
// - Input stage bit 7: 0 drives termination common mode, 1 floats it.
// - Front-end select bits 6:5: 01 equalizer, 10 zero-gain path, others undefined.
// - Input stage bit 4: 0 manual equalizer gain, 1 automatic adaptation.
// - Input stage bits 3:0 set equalizer gain while manual control is selected.
// - Output control bit 4 disables data output; bit 5 squelches output data.
// - Output control bit 2: 0 enables half-rate recovered clock, 1 disables it.
// - Output control bit 1 set inverts output data polarity.
// - Output swing bits 7:4 set amplitude, about 50 mV steps, 4 to F.
// - Input sampled fast, decimated by downsampler, feeding a bang-bang phase detector.
// - Delay loop integrator steers phase shifter; second integrator steers oscillator frequency.
// - Third loop compares frequencies, sets initial oscillator word and decimation ratio.
// - Clock lagging data raises oscillator frequency and reduces phase shifter delay.
// - Loop filter is a pure integrator, driving static phase error to zero.
// - Oscillator word saturates at range edge; unbounded phase shifter keeps tracking.
// - Retiming FIFO absorbs up to 32 UI of clock mismatch.
// - Acquisition machine gets within 250 ppm, then phase loop closes remaining error.
// - Beyond 1000 ppm: flag lock loss, oscillator to bottom, ratio one, reacquire.
// - Acquire: double ratio while sampling fast, else raise oscillator; clear loss at 250 ppm.
package cdrf_pkg;

	// =============================================================
	// Register offsets and reset values
	localparam logic [7:0] OFS_INPUT_STAGE = 8'h16;
	localparam logic [7:0] OFS_OUT_CTRL    = 8'h1E;
	localparam logic [7:0] OFS_OUT_SWING   = 8'h1F;
	localparam logic [7:0] OFS_STATUS      = 8'h05;
	localparam logic [7:0] RST_INPUT_STAGE = 8'h20;
	localparam logic [7:0] RST_OUT_CTRL    = 8'h08;
	localparam logic [7:0] RST_OUT_SWING   = 8'hCC;
	localparam logic [5:0] RST_SYNC        = 6'h03;

	// =============================================================
	// Field positions and codes
	localparam int         BIT_TERM_FLOAT = 7;
	localparam int         SEL_HI         = 6;
	localparam int         SEL_LO         = 5;
	localparam int         BIT_AUTO_EQ    = 4;
	localparam int         GAIN_HI        = 3;
	localparam int         BIT_SQUELCH    = 5;
	localparam int         BIT_OUTPUT_OFF = 4;
	localparam int         BIT_DDR_OFF    = 2;
	localparam int         BIT_POLARITY   = 1;
	localparam int         SWING_HI       = 7;
	localparam int         SWING_LO       = 4;
	localparam int         ST_LOSS        = 7;
	localparam int         ST_OVF         = 6;
	localparam logic [1:0] SEL_EQUALIZER  = 2'h1;
	localparam logic [1:0] SEL_ZERO_GAIN  = 2'h2;

	// =============================================================
	// Loop limits
	localparam int FIFO_UI    = 32;
	localparam int LOSS_PPM   = 1000;
	localparam int LOCK_PPM   = 250;
	localparam int PPM_SCALE  = 1000000;

	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WR, I_RD} cdrf_i2c_type;
	typedef enum logic {A_ACQ, A_TRACK} cdrf_acq_type;

endpackage : cdrf_pkg

/* dv/cdrf_source.sv */
// Serial data source model feeding the sampled line inputs
`timescale 1ns/1ps
`default_nettype none
module cdrf_source (
	// Clock
	input  wire logic clk,
	// Sampled line and rate ticks
	output logic      din_smp,
	output logic      edge_smp,
	output logic      osc_tick,
	output logic      data_tick
);
	// =============================================================
	// Pattern and rates
	logic [6:0] lfsr_ff = 7'h5A;
	logic [2:0] cnt_ff  = 3'h0;

	// Source runs free, like a live optical link; no idle state
	always @(negedge clk) begin
		cnt_ff  <= cnt_ff + 3'h1;
		lfsr_ff <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
	end

	// Oscillator ticks at twice the data rate, so acquisition must act
	// Data lock only: no reference clock is offered, so no ratios are written
	assign din_smp   = lfsr_ff[0];
	assign edge_smp  = lfsr_ff[1];
	assign osc_tick  = cnt_ff[1];
	assign data_tick = cnt_ff[2];
endmodule : cdrf_source
`default_nettype wire

/* dv/tb_top.sv */
// Testbench of the clock recovery front end register port
`timescale 1ns/1ps
`default_nettype none
module tb_top import cdrf_pkg::*;;
	// =============================================================
	// Signals
	logic        clk, rstn, scl_in, sda_low, retime_tick, sda_out, sda_oe;
	logic        din_smp, edge_smp, osc_tick, data_tick, dout;
	logic        term_q, auto_q, off_q, ddr_q, lol_q;
	logic [1:0]  path_q;
	logic [3:0]  adapt_gain, gain_q, swing_q, div_q;
	logic [7:0]  rd_v, phase_q;
	logic [11:0] osc_q;
	wire         sda_in = !(sda_low | (sda_oe === 1'b1));
	int          n_errors, samples_checked;

	localparam logic [6:0] DEV_ADDR_TB = 7'h40;

	cdrf_top #(.WIN_CYC(64)) cdrf_top_inst (.clk(clk), .rstn(rstn), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .din_smp(din_smp),
		.edge_smp(edge_smp), .osc_tick(osc_tick), .data_tick(data_tick),
		.retime_tick(retime_tick), .adapt_gain(adapt_gain), .term_float(term_q),
		.eq_path(path_q), .auto_equalize_enable(auto_q), .equalizer_gain(gain_q),
		.dout(dout), .output_off_bit(off_q), .ddr_clk_off(ddr_q), .swing(swing_q),
		.digital_oscillator(osc_q), .phase_word(phase_q), .div_exp(div_q),
		.lock_loss_flag(lol_q));
	cdrf_source cdrf_source_inst (.clk(clk), .din_smp(din_smp), .edge_smp(edge_smp),
		.osc_tick(osc_tick), .data_tick(data_tick));

	// =============================================================
	// Checking and closing
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	// =============================================================
	// Serial port tasks, pins moved at the falling clock edge
	task automatic clk_n(input int n);
		repeat (n) @(negedge clk);
	endtask : clk_n

	// Data moves one cycle after scl falls, never while scl is high
	task automatic bit_out(input logic b);
		clk_n(1);
		sda_low = !b;
		clk_n(5);
		scl_in = 1'b1;
		clk_n(5);
		scl_in = 1'b0;
	endtask : bit_out

	task automatic start_cond;
		clk_n(1);
		sda_low = 1'b0;
		clk_n(5);
		scl_in = 1'b1;
		clk_n(5);
		sda_low = 1'b1;
		clk_n(5);
		scl_in = 1'b0;
	endtask : start_cond

	task automatic stop_cond;
		clk_n(1);
		sda_low = 1'b1;
		clk_n(5);
		scl_in = 1'b1;
		clk_n(5);
		sda_low = 1'b0;
		clk_n(5);
	endtask : stop_cond

	task automatic byte_wr(input logic [7:0] b, input logic ack_exp);
		logic ack;
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		clk_n(1);
		sda_low = 1'b0;
		clk_n(5);
		scl_in = 1'b1;
		clk_n(2);
		ack = !sda_in;
		clk_n(3);
		scl_in = 1'b0;
		chk({7'h00, ack}, {7'h00, ack_exp});
	endtask : byte_wr

	task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d0, input logic [7:0] d1,
		input logic two);
		start_cond();
		byte_wr({DEV_ADDR_TB, 1'b0}, 1'b1);
		byte_wr(ofs, 1'b1);
		byte_wr(d0, 1'b1);
		if (two) begin
			byte_wr(d1, 1'b1);
		end
		stop_cond();
		clk_n(5);
	endtask : reg_wr

	// Single byte read, ended by the master not acknowledging
	task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] v);
		start_cond();
		byte_wr({DEV_ADDR_TB, 1'b0}, 1'b1);
		byte_wr(ofs, 1'b1);
		start_cond();
		byte_wr({DEV_ADDR_TB, 1'b1}, 1'b1);
		sda_low = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			clk_n(6);
			scl_in = 1'b1;
			clk_n(2);
			v[i] = sda_in;
			clk_n(3);
			scl_in = 1'b0;
		end
		bit_out(1'b1);
		stop_cond();
	endtask : reg_rd

	// =============================================================
	// Clock, watchdog and test sequence

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		clk_n(40000);
		n_errors++;
		stop_test();
	end

	initial begin
		rstn = 1'b0;
		scl_in = 1'b1;
		sda_low = 1'b0;
		retime_tick = 1'b0;
		adapt_gain = 4'h9;
		n_errors = 0;
		samples_checked = 0;
		clk_n(20);
		rstn = 1'b1;
		clk_n(5);
		chk({term_q, path_q, auto_q, gain_q}, RST_INPUT_STAGE);
		chk({off_q, ddr_q, 2'h0, swing_q}, 8'h0C);
		chk({lol_q, 3'h0, div_q}, 8'h80);
		chk(osc_q[7:0] | 8'(osc_q[11:8]), 8'h00);
		chk(phase_q, 8'h00);
		reg_rd(OFS_INPUT_STAGE, rd_v);
		chk(rd_v, RST_INPUT_STAGE);
		reg_rd(OFS_OUT_CTRL, rd_v);
		chk(rd_v, RST_OUT_CTRL);
		reg_rd(OFS_OUT_SWING, rd_v);
		chk(rd_v, RST_OUT_SWING);
		$display("Test reset values done");
		// Float, zero gain path, adaptive gain follows the adaptation input
		reg_wr(OFS_INPUT_STAGE, 8'hD5, 8'h00, 1'b0);
		chk({term_q, path_q, auto_q, 4'h0}, 8'hD0);
		chk({4'h0, gain_q}, 8'h09);
		reg_wr(OFS_INPUT_STAGE, 8'h2A, 8'h00, 1'b0);
		chk({term_q, path_q, auto_q, gain_q}, 8'h2A);
		reg_rd(OFS_INPUT_STAGE, rd_v);
		chk(rd_v, 8'h2A);
		$display("Test input stage done");
		// Two bytes through the auto-incrementing pointer
		retime_tick = 1'b1;
		reg_wr(OFS_OUT_CTRL, 8'h3E, 8'hFC, 1'b1);
		chk({off_q, ddr_q, 2'h0, swing_q}, 8'hCF);
		clk_n(40);
		chk({7'h00, dout}, 8'h00);
		reg_rd(OFS_OUT_CTRL, rd_v);
		chk(rd_v, 8'h3E);
		reg_rd(OFS_OUT_SWING, rd_v);
		chk(rd_v, 8'hFC);
		reg_wr(OFS_OUT_CTRL, 8'h08, 8'h4C, 1'b1);
		chk({off_q, ddr_q, 2'h0, swing_q}, 8'h04);
		$display("Test output control done");
		// Refusals: unmapped offset and a foreign address
		reg_rd(8'h40, rd_v);
		chk(rd_v, 8'h00);
		start_cond();
		byte_wr({DEV_ADDR_TB ^ 7'h01, 1'b0}, 1'b0);
		stop_cond();
		$display("Test refusals done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
